// [hdl/monitor_edid_link_control.sv]
// Summary of operation
// - vertical-clock transmit-only link for first mode
// - one shared post-incrementing buffer pointer
// - four registers at consecutive addresses
// - size bit picks 256 or 128, wraps
// - small region leaves upper half to system
// - software feed interrupts at ninth bit
// - hardware feed refills hold from buffer
// - byte request flag, software feed only, sticky
// - link enable off ignores vertical clock
// - i2c clock fall switches mode, flags
// - mode flag zero vsync, one i2c
// - second i2c registers behave as standard
// - buffer port access increments pointer, held in small upper half
// - switch to i2c within three clocks
// - nine sync cycles released, msb tenth
// - hold register holds next byte sent
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "ddc_link_regs.svh"
module monitor_edid_link_control #(
	parameter int BUF_DEPTH = 256
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire ddc_link_pkg::byte_t regAddr,
	input wire ddc_link_pkg::byte_t regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output ddc_link_pkg::byte_t regRdata,
	input wire logic vclkPin,
	input wire logic i2cClockPin,
	output logic sdaOut,
	output logic sdaOe,
	output logic irqOut,
	output ddc_link_pkg::vector_t irqVector,
	input wire ddc_link_pkg::byte_t i2cEngineState,
	input wire ddc_link_pkg::byte_t i2cEngineData,
	input wire logic i2cEngineLoad,
	output ddc_link_pkg::byte_t i2cControl,
	output ddc_link_pkg::byte_t i2cShiftData,
	output ddc_link_pkg::byte_t i2cOwnAddress,
	output logic i2cDataWritten
);
	import ddc_link_pkg::*;

	// edid and system buffer
	// not reset: software loads it before enabling
	// lower half edid, upper half free when small
	byte_t bufferRam [0:BUF_DEPTH-1];
	// shared post-incrementing pointer
	// one pointer serves both protocol modes
	byte_t ptr_r;
	// hold byte for the transmitter
	// always the next byte to leave on the link
	byte_t hold_r;
	// control fields
	// written together by one control write
	logic extSize_r; // 256-byte region
	logic swFeed_r; // cpu feeds the hold byte
	logic linkEn_r; // vertical clock link enabled
	logic linkMode_r; // 0 vsync link, 1 i2c link
	// sticky interrupt flags
	// set by hardware, cleared by writing one
	logic byteReq_r;
	logic modeSw_r;
	// interrupt mask, same layout as control
	// only the two flag positions are kept
	byte_t mask_r;
	// hardware refill waiting for a free cycle
	// refill loses a cycle to a software port access
	// so the pointer never steps twice in one cycle
	logic fetchPend_r;
	// pin synchronisers
	// one shift register per pin, newest bit lowest
	logic [2:0] vclkSync_r;
	logic [2:0] sclSync_r;
	// decoded bus and link events
	// all on the system clock, no second domain
	logic vclkRise;
	logic sclFall;
	logic swBufAccess;
	logic ctrlWrite;
	logic hwFetch;
	byte_t ctrlView;
	byte_t i2cRdData;
	logic i2cHit;

	// carrier between control and transmitter
	ddc_tx_if txLink ();

	// step the pointer inside the selected region only
	// large region: plain 8-bit roll-over
	// small region: top of lower half wraps to zero
	// upper half: held, software addresses it freely
	function automatic byte_t ptrNext(input byte_t p, input logic ext);
		byte_t n;
		n = p;
		if (ext) begin
			n = p + `PTR_ONE;
		end else if (p == `REGION_TOP_SMALL) begin
			n = `BYTE_ZERO;
		end else if (!p[7]) begin
			n = p + `PTR_ONE;
		end else begin
			n = p;
		end
		return n;
	endfunction

	// three-stage pin synchronisers
	// first stage may go metastable, only stage two reads it
	// reset to the idle levels so no false edge follows reset
	// clock line idles high, vertical clock idles low
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			vclkSync_r <= 3'h0;
			sclSync_r <= 3'h7;
		end else begin
			vclkSync_r <= {vclkSync_r[1:0], vclkPin};
			sclSync_r <= {sclSync_r[1:0], i2cClockPin};
		end
	end

	// edges from the agreeing late stages
	// one-cycle pulses, about two clocks behind the pin
	// hazard: a pin pulse shorter than one clock can be lost
	// the clock line is watched for its fall only
	assign vclkRise = vclkSync_r[1] && !vclkSync_r[2];
	assign sclFall = !sclSync_r[1] && sclSync_r[2];

	// transmitter runs only when enabled and in vsync mode
	// dropping run resets the transmitter and frees the line
	// a stopped link ignores the vertical clock entirely
	assign txLink.run = linkEn_r && !linkMode_r;
	assign txLink.bitRise = vclkRise && txLink.run;
	assign txLink.holdByte = hold_r;
	assign sdaOut = txLink.sdaOut;
	assign sdaOe = txLink.sdaOe;

	ddc1_transmitter transmitter (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.link(txLink)
	);

	// bus decode
	// reads and writes of the data port both step the pointer
	// the refill defers to software in the same cycle
	// decodes are plain compares, no wait states
	assign swBufAccess = (regWrite || regRead) && regAddr == `OFS_BUFFER_DATA;
	assign ctrlWrite = regWrite && regAddr == `OFS_LINK_CTRL;
	assign hwFetch = fetchPend_r && !swBufAccess;

	// buffer writes from software through the data port
	// no reset on the memory, it holds no control state
	// the write lands at the pointer before it steps
	always_ff @(posedge clk_sys) begin
		if (regWrite && regAddr == `OFS_BUFFER_DATA) begin
			bufferRam[ptr_r] <= regWdata;
		end
	end

	// refill request waits while software owns the port
	// set by the transmitter's byte request in hardware feed
	// cleared once the refill takes its cycle
	// a stopped link forgets a pending refill
	always_ff @(posedge clk_sys) begin
		if (!nrst || !txLink.run) begin
			fetchPend_r <= 1'b0;
		end else if (txLink.needByte && !swFeed_r) begin
			fetchPend_r <= 1'b1;
		end else if (hwFetch) begin
			fetchPend_r <= 1'b0;
		end
	end

	// pointer: software write, or region step on any port access
	// a direct pointer write beats a port access in the same cycle
	// hardware refills step it exactly as software reads do
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ptr_r <= `PTR_RESET;
		end else if (regWrite && regAddr == `OFS_BUFFER_PTR) begin
			ptr_r <= regWdata;
		end else if (swBufAccess || hwFetch) begin
			ptr_r <= ptrNext(ptr_r, extSize_r);
		end
	end

	// hold byte: software load or hardware refill
	// software load wins if a refill falls in the same cycle
	// in software feed only the cpu ever writes it
	// hazard: a late load sends the stale byte again
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			hold_r <= `HOLD_RESET;
		end else if (regWrite && regAddr == `OFS_HOLD_BYTE) begin
			hold_r <= regWdata;
		end else if (hwFetch) begin
			hold_r <= bufferRam[ptr_r];
		end
	end

	// configuration bits of the control register
	// mode and flag positions are handled elsewhere
	// reserved positions are dropped on the floor
	// clearing the enable stops a frame at once
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			extSize_r <= 1'b0;
			swFeed_r <= 1'b0;
			linkEn_r <= 1'b0;
		end else if (ctrlWrite) begin
			extSize_r <= regWdata[`BIT_EXT_SIZE];
			swFeed_r <= regWdata[`BIT_SW_FEED];
			linkEn_r <= regWdata[`BIT_LINK_EN];
		end
	end

	// mode flag: i2c clock fall wins over a software write
	// switch only leaves the vsync mode on its own
	// software may write it back to zero to restart
	// taken whether or not the link is enabled
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			linkMode_r <= 1'b0;
		end else if (sclFall && !linkMode_r) begin
			linkMode_r <= 1'b1;
		end else if (ctrlWrite) begin
			linkMode_r <= regWdata[`BIT_LINK_MODE];
		end
	end

	// byte request flag: set only in software feed, write one clears
	// set wins over a clear in the same cycle
	// writing zero leaves the flag as it stands
	// only a running link raises the request
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			byteReq_r <= 1'b0;
		end else if (txLink.needByte && swFeed_r) begin
			byteReq_r <= 1'b1;
		end else if (ctrlWrite && regWdata[`BIT_BYTE_REQ]) begin
			byteReq_r <= 1'b0;
		end
	end

	// mode switch flag: set on the switch, write one clears
	// set wins over a clear in the same cycle
	// raised once per switch, not per clock fall
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			modeSw_r <= 1'b0;
		end else if (sclFall && !linkMode_r) begin
			modeSw_r <= 1'b1;
		end else if (ctrlWrite && regWdata[`BIT_MODE_SW]) begin
			modeSw_r <= 1'b0;
		end
	end

	// interrupt mask, only flag positions stored
	// same layout as control, other bits read zero
	// a zero mask keeps the interrupt line quiet
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mask_r <= `MASK_RESET;
		end else if (regWrite && regAddr == `OFS_IRQ_MASK) begin
			mask_r <= regWdata & `IRQ_BITS;
		end
	end

	// control view, reserved bits zero
	// shared by the read mux and the interrupt gate
	// bits 7 and 4 never carry state
	always_comb begin
		ctrlView = `BYTE_ZERO;
		ctrlView[`BIT_EXT_SIZE] = extSize_r;
		ctrlView[`BIT_SW_FEED] = swFeed_r;
		ctrlView[`BIT_BYTE_REQ] = byteReq_r;
		ctrlView[`BIT_LINK_EN] = linkEn_r;
		ctrlView[`BIT_MODE_SW] = modeSw_r;
		ctrlView[`BIT_LINK_MODE] = linkMode_r;
	end

	// level interrupt on the shared vector while any unmasked flag stands
	// one register stage, so the line lags its flag by a cycle
	// both flags share the one vector
	// the line drops a cycle after software clears the flag
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			irqOut <= 1'b0;
			irqVector <= `IRQ_VECTOR;
		end else begin
			irqOut <= |(ctrlView & mask_r & `IRQ_BITS);
			irqVector <= `IRQ_VECTOR;
		end
	end

	// second i2c register copies
	// the engine itself sits outside this block
	// its state byte is read straight through
	// writes at the copies go through unchanged
	second_i2c_regs i2cRegs (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWrite(regWrite),
		.rdData(i2cRdData),
		.hit(i2cHit),
		.engineState(i2cEngineState),
		.engineData(i2cEngineData),
		.engineLoad(i2cEngineLoad),
		.control(i2cControl),
		.shiftData(i2cShiftData),
		.ownAddress(i2cOwnAddress),
		.dataWritten(i2cDataWritten)
	);

	// read data one cycle after the strobe, zero otherwise
	// data stands for one cycle only, the bus never waits
	// unmapped addresses read zero
	// a data port read returns the byte at the old pointer
	always_ff @(posedge clk_sys) begin
		if (!nrst || !regRead) begin
			regRdata <= `BYTE_ZERO;
		end else if (regAddr == `OFS_BUFFER_DATA) begin
			regRdata <= bufferRam[ptr_r];
		end else if (regAddr == `OFS_LINK_CTRL) begin
			regRdata <= ctrlView;
		end else if (regAddr == `OFS_BUFFER_PTR) begin
			regRdata <= ptr_r;
		end else if (regAddr == `OFS_HOLD_BYTE) begin
			regRdata <= hold_r;
		end else if (regAddr == `OFS_IRQ_MASK) begin
			regRdata <= mask_r;
		end else if (i2cHit) begin
			regRdata <= i2cRdData;
		end else begin
			regRdata <= `BYTE_ZERO;
		end
	end
endmodule // monitor_edid_link_control
`default_nettype wire

// [pkg/ddc_link_regs.svh]
`ifndef DDC_LINK_REGS_SVH
`define DDC_LINK_REGS_SVH
// register offsets on the plain register port
`define OFS_BUFFER_DATA 8'h9c
`define OFS_LINK_CTRL 8'h9d
`define OFS_BUFFER_PTR 8'h9e
`define OFS_HOLD_BYTE 8'h9f
`define OFS_IRQ_MASK 8'ha1
`define OFS_I2C_CONTROL 8'hd8
`define OFS_I2C_STATE 8'hd9
`define OFS_I2C_DATA 8'hda
`define OFS_I2C_OWN_ADDR 8'hdb
// link_control_status field positions
`define BIT_EXT_SIZE 6
`define BIT_SW_FEED 5
`define BIT_BYTE_REQ 3
`define BIT_LINK_EN 2
`define BIT_MODE_SW 1
`define BIT_LINK_MODE 0
// reset values and masks
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
`define PTR_RESET 8'h00
`define HOLD_RESET 8'h00
`define I2C_RESET 8'h00
`define BYTE_ZERO 8'h00
`define IRQ_BITS 8'h0a
// pointer region limits
`define REGION_TOP_SMALL 8'h7f
`define PTR_ONE 8'h01
// link timing in vertical clock cycles
`define SYNC_LAST 4'h8
`define SEND_FIRST 4'h9
`define BIT_NINTH 4'h8
`define BIT_EIGHTH 4'h7
`define COUNT_ZERO 4'h0
`define COUNT_ONE 4'h1
// shared interrupt vector address
`define IRQ_VECTOR 16'h002b
`endif

// [pkg/ddc_link_pkg.sv]
`default_nettype none
package ddc_link_pkg;
	// one byte of register or buffer data
	typedef logic [7:0] byte_t;
	// vector address word
	typedef logic [15:0] vector_t;
	// transmitter states, one-hot
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SYNC = 3'b010,
		TX_SEND = 3'b100
	} tx_state_t;
endpackage
`default_nettype wire

// [pkg/ddc_tx_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ddc_tx_if;
	import ddc_link_pkg::*;
	logic run; // link active, enable and mode agree
	logic bitRise; // one-cycle pulse per vertical clock rise
	byte_t holdByte; // byte to send next
	logic sdaOut; // serial data level
	logic sdaOe; // output enable, low while driving
	logic needByte; // one-cycle pulse, next byte wanted
	modport ctl (output run, output bitRise, output holdByte,
		input sdaOut, input sdaOe, input needByte);
	modport tx (input run, input bitRise, input holdByte,
		output sdaOut, output sdaOe, output needByte);
endinterface
`default_nettype wire

// [hdl/ddc1_transmitter.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ddc_link_regs.svh"
module ddc1_transmitter (
	input wire logic clk_sys,
	input wire logic nrst,
	ddc_tx_if.tx link
);
	import ddc_link_pkg::*;
	tx_state_t state_r; // sync or send phase
	logic [3:0] count_r; // sync rises, then bit index
	byte_t shift_r; // byte under transmission

	// phase and counter, dropped whenever the link stops
	always_ff @(posedge clk_sys) begin
		if (!nrst || !link.run) begin
			state_r <= TX_IDLE;
			count_r <= `COUNT_ZERO;
		end else begin
			case (state_r)
				TX_IDLE: begin
					state_r <= TX_SYNC;
					count_r <= `COUNT_ZERO;
				end
				TX_SYNC: begin
					// nine sync cycles, then the tenth rise sends
					if (link.bitRise) begin
						if (count_r == `SEND_FIRST) begin
							state_r <= TX_SEND;
							count_r <= `COUNT_ZERO;
						end else begin
							count_r <= count_r + `COUNT_ONE;
						end
					end
				end
				TX_SEND: begin
					// nine bit times per byte
					if (link.bitRise) begin
						if (count_r == `BIT_NINTH) begin
							count_r <= `COUNT_ZERO;
						end else begin
							count_r <= count_r + `COUNT_ONE;
						end
					end
				end
				default: begin
					state_r <= TX_IDLE;
					count_r <= `COUNT_ZERO;
				end
			endcase
		end
	end

	// serial data pin, released during sync and the ninth bit
	always_ff @(posedge clk_sys) begin
		if (!nrst || !link.run) begin
			shift_r <= `BYTE_ZERO;
			link.sdaOut <= 1'b1;
			link.sdaOe <= 1'b1;
		end else if (link.bitRise) begin
			if ((state_r == TX_SYNC && count_r == `SEND_FIRST) ||
				(state_r == TX_SEND && count_r == `BIT_NINTH)) begin
				// load the hold byte, msb first
				shift_r <= link.holdByte;
				link.sdaOut <= link.holdByte[7];
				link.sdaOe <= 1'b0;
			end else if (state_r == TX_SEND && count_r == `BIT_EIGHTH) begin
				// ninth bit, line released
				link.sdaOut <= 1'b1;
				link.sdaOe <= 1'b1;
			end else if (state_r == TX_SEND) begin
				// next data bit
				shift_r <= {shift_r[6:0], 1'b0};
				link.sdaOut <= shift_r[6];
			end
		end
	end

	// byte request at the ninth sync cycle and each ninth bit
	always_ff @(posedge clk_sys) begin
		if (!nrst || !link.run) begin
			link.needByte <= 1'b0;
		end else begin
			link.needByte <= link.bitRise &&
				((state_r == TX_SYNC && count_r == `SYNC_LAST) ||
				(state_r == TX_SEND && count_r == `BIT_EIGHTH));
		end
	end
endmodule // ddc1_transmitter
`default_nettype wire

// [hdl/second_i2c_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ddc_link_regs.svh"
module second_i2c_regs (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire ddc_link_pkg::byte_t regAddr,
	input wire ddc_link_pkg::byte_t regWdata,
	input wire logic regWrite,
	output ddc_link_pkg::byte_t rdData,
	output logic hit,
	input wire ddc_link_pkg::byte_t engineState,
	input wire ddc_link_pkg::byte_t engineData,
	input wire logic engineLoad,
	output ddc_link_pkg::byte_t control,
	output ddc_link_pkg::byte_t shiftData,
	output ddc_link_pkg::byte_t ownAddress,
	output logic dataWritten
);
	import ddc_link_pkg::*;

	// software copies of the engine registers
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			control <= `I2C_RESET;
			ownAddress <= `I2C_RESET;
		end else if (regWrite) begin
			if (regAddr == `OFS_I2C_CONTROL) begin
				control <= regWdata;
			end else if (regAddr == `OFS_I2C_OWN_ADDR) begin
				ownAddress <= regWdata;
			end
		end
	end

	// shift data: software write, else the engine's received byte
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			shiftData <= `I2C_RESET;
			dataWritten <= 1'b0;
		end else begin
			dataWritten <= regWrite && regAddr == `OFS_I2C_DATA;
			if (regWrite && regAddr == `OFS_I2C_DATA) begin
				shiftData <= regWdata;
			end else if (engineLoad) begin
				shiftData <= engineData;
			end
		end
	end

	// read view, state comes straight from the engine
	always_comb begin
		hit = 1'b1;
		if (regAddr == `OFS_I2C_CONTROL) begin
			rdData = control;
		end else if (regAddr == `OFS_I2C_STATE) begin
			rdData = engineState;
		end else if (regAddr == `OFS_I2C_DATA) begin
			rdData = shiftData;
		end else if (regAddr == `OFS_I2C_OWN_ADDR) begin
			rdData = ownAddress;
		end else begin
			rdData = `BYTE_ZERO;
			hit = 1'b0;
		end
	end
endmodule // second_i2c_regs
`default_nettype wire

// [bench/edid_link_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module edid_link_sva #(
	parameter int BUF_DEPTH = 256
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire ddc_link_pkg::byte_t regAddr,
	input wire ddc_link_pkg::byte_t regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire ddc_link_pkg::byte_t regRdata,
	input wire logic vclkPin,
	input wire logic i2cClockPin,
	input wire logic sdaOe,
	input wire logic irqOut,
	input wire ddc_link_pkg::vector_t irqVector,
	input wire ddc_link_pkg::byte_t i2cControl,
	input wire logic i2cDataWritten
);
	import ddc_link_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// one strobe at a given address
	sequence s_wr(a); regWrite && regAddr == a; endsequence
	sequence s_rd(a); regRead && regAddr == a; endsequence
	// pins and bus quiet for eight samples
	sequence s_quiet;
		(!regWrite && $stable(vclkPin) && $stable(i2cClockPin)) [*8];
	endsequence
	vec_const_a: assert property (irqVector == 16'h002b) else $error("vector moved");
	rd_idle_a: assert property (!regRead |=> regRdata == 8'h00) else $error("stray data");
	rd_resv_a: assert property (s_rd(8'h9d) |=> !regRdata[7] && !regRdata[4])
		else $error("reserved bit set");
	rd_unmap_a: assert property (regRead && regAddr < 8'h9c |=> regRdata == 8'h00)
		else $error("unmapped read data");
	ctl_copy_a: assert property (s_wr(8'hd8) |=> i2cControl == $past(regWdata))
		else $error("control copy wrong");
	dw_pulse_a: assert property (s_wr(8'hda) |=> i2cDataWritten) else $error("no pulse");
	dw_cause_a: assert property (i2cDataWritten |-> $past(regWrite && regAddr == 8'hda))
		else $error("pulse without write");
	irq_fall_a: assert property ($fell(irqOut) |-> $past(regWrite, 2) || $past(regWrite, 3))
		else $error("irq dropped alone");
	oe_still_a: assert property (s_quiet |-> $stable(sdaOe)) else $error("data moved");
	scl_oe_a: assert property ($fell(i2cClockPin) |-> ##[1:4] sdaOe)
		else $error("link kept driving");
endmodule // edid_link_sva
`default_nettype wire

// [bench/vsync_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vsync_host_model (
	output var logic vclkPin,
	output var logic i2cClockPin,
	input wire logic sdaOut,
	input wire logic sdaOe
);
	logic sdaLine; // pulled up when released
	logic [1:0] seen[$]; // {enable, line} per period
	assign sdaLine = sdaOe ? 1'b1 : sdaOut;
	// clocks stand still between frames
	initial begin
		vclkPin = 1'b0;
		i2cClockPin = 1'b1;
	end
	// n periods of 160 ns, sampled just before the next rise
	task pulses(input int n);
		#7;
		repeat (n) begin
			vclkPin = 1'b1;
			#80;
			vclkPin = 1'b0;
			#80;
			seen.push_back({sdaOe, sdaLine});
		end
	endtask
	// second-mode host starts clocking
	task sclFall;
		#7;
		i2cClockPin = 1'b0;
	endtask
endmodule // vsync_host_model
`default_nettype wire

// [bench/monitor_edid_link_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module monitor_edid_link_control_tb_top;
	import ddc_link_pkg::*;
	logic clk_sys, nrst, regWrite, regRead, vclkPin, i2cClockPin;
	logic sdaOut, sdaOe, irqOut, engLoad, i2cDataWritten;
	byte_t regAddr, regWdata, regRdata, engState, engData;
	byte_t i2cControl, i2cShiftData, i2cOwnAddress;
	vector_t irqVector;
	int mismatches, n_tests, cycles;
	monitor_edid_link_control #(.BUF_DEPTH(256)) i_monitor_edid_link_control (
		.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.vclkPin(vclkPin), .i2cClockPin(i2cClockPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.irqOut(irqOut), .irqVector(irqVector), .i2cEngineState(engState),
		.i2cEngineData(engData), .i2cEngineLoad(engLoad), .i2cControl(i2cControl),
		.i2cShiftData(i2cShiftData), .i2cOwnAddress(i2cOwnAddress),
		.i2cDataWritten(i2cDataWritten));
	vsync_host_model i_vsync_host_model (.vclkPin(vclkPin),
		.i2cClockPin(i2cClockPin), .sdaOut(sdaOut), .sdaOe(sdaOe));
	// 50 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up;
		end
	end
	task wrap_up;
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one-cycle write, then a quiet cycle
	task wr(input byte_t a, input byte_t d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	// read, data taken in the slot after the strobe
	task rc(input byte_t a, input byte_t e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1 chk(regRdata, e);
		@(posedge clk_sys);
	endtask
	// host periods, then back onto the clock
	task hp(input int n);
		i_vsync_host_model.pulses(n);
		@(posedge clk_sys);
	endtask
	// nine captured periods against a byte or release
	task chkSeen(input byte_t b, input logic rel);
		logic [1:0] e;
		for (int i = 0; i < 9; i++) begin
			e = (rel || i == 8) ? 2'b11 : {1'b0, b[7 - i]};
			chk(i_vsync_host_model.seen[i], e);
		end
		i_vsync_host_model.seen.delete();
	endtask
	task t_reset;
		rc(8'h9d, 8'h00);
		rc(8'h9e, 8'h00);
		rc(8'h9f, 8'h00);
		rc(8'ha1, 8'h00);
		rc(8'h9b, 8'h00);
		chk(sdaOe, 1'b1);
		chk(irqVector, 16'h002b);
	endtask
	task t_regs;
		wr(8'h9d, 8'hd0);
		rc(8'h9d, 8'h40);
		wr(8'h9e, 8'hff);
		wr(8'h9c, 8'h11);
		rc(8'h9e, 8'h00);
		wr(8'h9d, 8'h00);
		wr(8'h9e, 8'h7e);
		wr(8'h9c, 8'ha1);
		wr(8'h9c, 8'ha2);
		rc(8'h9e, 8'h00);
		wr(8'h9e, 8'hc8);
		wr(8'h9c, 8'h55);
		rc(8'h9e, 8'hc8);
		rc(8'h9c, 8'h55);
		wr(8'h9e, 8'h7e);
		rc(8'h9c, 8'ha1);
		rc(8'h9e, 8'h7f);
	endtask
	task t_hwfeed;
		wr(8'h9e, 8'h00);
		wr(8'h9c, 8'hc3);
		wr(8'h9e, 8'h00);
		wr(8'h9d, 8'h04);
		hp(9);
		chkSeen(8'h00, 1'b1);
		rc(8'h9f, 8'hc3);
		rc(8'h9e, 8'h01);
		hp(9);
		chkSeen(8'hc3, 1'b0);
		rc(8'h9d, 8'h04);
	endtask
	task t_swfeed;
		wr(8'h9d, 8'h00);
		wr(8'h9d, 8'h24);
		hp(9);
		i_vsync_host_model.seen.delete();
		rc(8'h9d, 8'h2c);
		#1 chk(irqOut, 1'b0);
		wr(8'ha1, 8'h0a);
		#1 chk(irqOut, 1'b1);
		wr(8'h9f, 8'h5a);
		wr(8'h9d, 8'h2c);
		#1 chk(irqOut, 1'b0);
		hp(9);
		chkSeen(8'h5a, 1'b0);
		rc(8'h9d, 8'h2c);
		rc(8'h9e, 8'h02);
	endtask
	task t_off;
		wr(8'h9d, 8'h08);
		hp(9);
		chkSeen(8'h00, 1'b1);
		rc(8'h9e, 8'h02);
		#1 chk(irqOut, 1'b0);
	endtask
	task t_i2c;
		wr(8'hd8, 8'h45);
		chk(i2cControl, 8'h45);
		wr(8'hda, 8'h66);
		rc(8'hda, 8'h66);
		rc(8'hd9, 8'hf8);
		wr(8'hdb, 8'ha4);
		chk(i2cOwnAddress, 8'ha4);
		chk(i2cShiftData, 8'h66);
		engData <= 8'h3c;
		engLoad <= 1'b1;
		@(posedge clk_sys);
		engLoad <= 1'b0;
		rc(8'hda, 8'h3c);
	endtask
	task t_switch;
		wr(8'h9d, 8'h04);
		i_vsync_host_model.sclFall;
		repeat (3) @(posedge clk_sys);
		rc(8'h9d, 8'h07);
		#1 chk(irqOut, 1'b1);
		wr(8'h9d, 8'h07);
		rc(8'h9d, 8'h05);
	endtask
	// reset, then the scenarios in turn
	initial begin
		nrst <= 1'b0;
		regAddr <= 8'h00;
		regWdata <= 8'h00;
		regWrite <= 1'b0;
		regRead <= 1'b0;
		engState <= 8'hf8;
		engData <= 8'h00;
		engLoad <= 1'b0;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_regs;
		t_hwfeed;
		t_swfeed;
		t_off;
		t_i2c;
		t_switch;
		wrap_up;
	end
endmodule // monitor_edid_link_control_tb_top
bind monitor_edid_link_control edid_link_sva #(.BUF_DEPTH(BUF_DEPTH)) i_edid_link_sva (
	.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .vclkPin(vclkPin),
	.i2cClockPin(i2cClockPin), .sdaOe(sdaOe), .irqOut(irqOut), .irqVector(irqVector),
	.i2cControl(i2cControl), .i2cDataWritten(i2cDataWritten));
`default_nettype wire
